// ===== verilog/ccg_params.svh
// constants and behaviour summary for the capture/compare gating control slice
// Behaviour
// - pin_steer_enable set drives the compare pin from the unit, else port logic
// - gate mode 00: capture events pass while gate is high, blocked while low
// - gate mode 01: gate rising edge clears capture_disable_flag, enabling capture
// - gate mode 10: gate falling edge sets capture_disable_flag; code 11 reserved
// - aux select: 00 off, 01 rollover, 10 mode signal, 11 capture/compare event outside timer mode, low in timer mode
// - source 000 takes capture events from the remappable capture input pin
`ifndef CCG_PARAMS_SVH
`define CCG_PARAMS_SVH

// register byte addresses
`define CCG_ADDR_CTRL       4'h0
`define CCG_ADDR_STATUS     4'h4
`define CCG_ADDR_MASK       4'h8
`define CCG_ADDR_IRQ        4'hc

// control register fields
`define CCG_CTRL_IMPL       16'h81df
`define CCG_BIT_OE_SYNC     15
`define CCG_BIT_PIN_STEER   8
`define CCG_GSM_HI          7
`define CCG_GSM_LO          6
`define CCG_AUX_HI          4
`define CCG_AUX_LO          3
`define CCG_SRC_HI          2
`define CCG_SRC_LO          0
`define CCG_STAT_W          3

// status bits: 0 capture event, 1 gate disable change, 2 aux event
`define CCG_GSM_LEVEL       2'h0
`define CCG_GSM_RISE        2'h1
`define CCG_GSM_FALL        2'h2
`define CCG_AUX_OFF         2'h0
`define CCG_AUX_ROLL        2'h1
`define CCG_AUX_MODE        2'h2
`define CCG_AUX_EVENT       2'h3

`endif

// ===== verilog/ccg_pkg.sv
// types for the capture/compare gating control slice
package ccg_pkg;
    typedef enum logic [1:0] {
        CCG_IDLE = 2'b00,
        CCG_RESP = 2'b01
    } ccg_bus_type;
endpackage

// ===== verilog/ccg_sync.sv
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module ccg_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ccg_sync_type;

    ccg_sync_type st;
    ccg_sync_type next_st;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            st <= '0;
        else
            st <= next_st;
    end

    assign dout = st.s2;
endmodule
`default_nettype wire

// ===== verilog/ccg_top.sv
// capture/compare gating control slice with avalon-mm register access
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ccg_params.svh"
module ccg_top (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output var  logic [31:0] readdata,
    output var  logic        waitrequest,
    input  wire logic [7:0]  capture_sources,
    input  wire logic        gate_in,
    input  wire logic        tb_rollover,
    input  wire logic        tb_reset,
    input  wire logic        mode_signal,
    input  wire logic        compare_event,
    input  wire logic        timer_mode,
    input  wire logic        compare_wave,
    input  wire logic        out_enable_req,
    output var  logic        compare_output_pin,
    output var  logic        compare_output_pin_oe,
    output var  logic        capture_event,
    output var  logic        aux_out,
    output var  logic        capture_disable_flag,
    output var  logic        irq
);
    // ==========================================================
    // state
    typedef struct packed {
        ccg_pkg::ccg_bus_type        bus;
        logic [15:0]                 ctrl;
        logic [`CCG_STAT_W-1:0]      status;
        logic [`CCG_STAT_W-1:0]      mask;
        logic [31:0]                 rdata;
        logic                        oe_applied;
        logic                        src_d;
        logic                        gate_d;
        logic                        dis;
        logic                        cap;
        logic                        aux;
        logic                        pin;
        logic                        pin_oe;
        logic                        irq;
        logic                        wait_req;
    } ccg_state_type;

    // waitrequest idles high, everything else clears
    localparam ccg_state_type CCG_RST_ST =
        ccg_state_type'({{($bits(ccg_state_type) - 1){1'b0}}, 1'b1});

    localparam int SRC_N = 8;

    ccg_state_type st;
    ccg_state_type next_st;

    logic [SRC_N:0] pins_s;

    ccg_sync #(
        .W (SRC_N + 1)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  ({gate_in, capture_sources}),
        .dout (pins_s)
    );

    // ==========================================================
    // helpers
    function automatic logic [31:0] ccg_pad(input logic [15:0] v);
        ccg_pad = {16'h0000, v};
    endfunction

    logic       src_now;
    logic       gate_now;
    logic       gate_open;
    logic       cap_ev;
    logic       dis_ev;
    logic       aux_now;
    logic [1:0] gsm;
    logic [1:0] auxsel;
    logic [2:0] srcsel;

    always_comb
    begin
        gsm      = st.ctrl[`CCG_GSM_HI:`CCG_GSM_LO];
        auxsel   = st.ctrl[`CCG_AUX_HI:`CCG_AUX_LO];
        srcsel   = st.ctrl[`CCG_SRC_HI:`CCG_SRC_LO];
        gate_now = pins_s[SRC_N];
        src_now  = pins_s[srcsel];
        gate_open = 1'b0;
        next_st  = st;
        next_st.src_d  = src_now;
        next_st.gate_d = gate_now;
        dis_ev = 1'b0;
        case (gsm)
            `CCG_GSM_LEVEL: gate_open = gate_now;
            `CCG_GSM_RISE:
            begin
                if (gate_now && !st.gate_d)
                    next_st.dis = 1'b0;
                gate_open = !st.dis;
            end
            `CCG_GSM_FALL:
            begin
                if (!gate_now && st.gate_d)
                    next_st.dis = 1'b1;
                gate_open = !st.dis;
            end
            default: gate_open = 1'b0;
        endcase
        dis_ev = next_st.dis != st.dis;
        cap_ev = src_now && !st.src_d && gate_open;
        next_st.cap = cap_ev;
        aux_now = 1'b0;
        case (auxsel)
            `CCG_AUX_OFF:   aux_now = 1'b0;
            `CCG_AUX_ROLL:  aux_now = tb_rollover;
            `CCG_AUX_MODE:  aux_now = mode_signal;
            `CCG_AUX_EVENT: aux_now = !timer_mode && (cap_ev || compare_event);
            default:        aux_now = 1'b0;
        endcase
        next_st.aux = aux_now;
        // output enable update, deferred or immediate
        if (!st.ctrl[`CCG_BIT_OE_SYNC] || tb_reset || tb_rollover)
            next_st.oe_applied = out_enable_req;
        next_st.pin_oe = st.ctrl[`CCG_BIT_PIN_STEER] && st.oe_applied;
        next_st.pin    = next_st.pin_oe ? compare_wave : 1'b0;
        // bus slave: one wait cycle, then response
        next_st.bus = ccg_pkg::CCG_IDLE;
        if (st.bus == ccg_pkg::CCG_IDLE && (read || write))
        begin
            next_st.bus = ccg_pkg::CCG_RESP;
            next_st.rdata = 32'h0000_0000;
            if (address == `CCG_ADDR_CTRL)
                next_st.rdata = ccg_pad(st.ctrl);
            else if (address == `CCG_ADDR_STATUS)
                next_st.rdata = {29'h0, st.status};
            else if (address == `CCG_ADDR_MASK)
                next_st.rdata = {29'h0, st.mask};
            else if (address == `CCG_ADDR_IRQ)
                next_st.rdata = {31'h0, st.irq};
        end
        if (st.bus == ccg_pkg::CCG_RESP && write)
        begin
            if (address == `CCG_ADDR_CTRL)
                next_st.ctrl = writedata[15:0] & `CCG_CTRL_IMPL;
            else if (address == `CCG_ADDR_STATUS)
                next_st.status = st.status & ~writedata[`CCG_STAT_W-1:0];
            else if (address == `CCG_ADDR_MASK)
                next_st.mask = writedata[`CCG_STAT_W-1:0];
        end
        // set wins over write-one clear
        next_st.status = next_st.status | {aux_now, dis_ev, cap_ev};
        next_st.irq = |(next_st.status & next_st.mask);
        next_st.wait_req = (next_st.bus != ccg_pkg::CCG_RESP);
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            st <= CCG_RST_ST;
        else
            st <= next_st;
    end

    assign readdata             = st.rdata;
    assign waitrequest          = st.wait_req;
    assign compare_output_pin   = st.pin;
    assign compare_output_pin_oe = st.pin_oe;
    assign capture_event        = st.cap;
    assign aux_out              = st.aux;
    assign capture_disable_flag = st.dis;
    assign irq                  = st.irq;

    // ==========================================================
    // checks
    property p_reserved_zero;
        @(posedge clk) disable iff (!nrst)
        (st.ctrl & ~`CCG_CTRL_IMPL) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_level_block;
        @(posedge clk) disable iff (!nrst)
        (gsm == `CCG_GSM_LEVEL && !gate_now) |=> !capture_event;
    endproperty
    a_level_block: assert property (p_level_block) else $error("capture while gate low");

    property p_rise_clear;
        @(posedge clk) disable iff (!nrst)
        (gsm == `CCG_GSM_RISE && gate_now && !st.gate_d) |=> !capture_disable_flag;
    endproperty
    a_rise_clear: assert property (p_rise_clear) else $error("rise did not clear");

    property p_fall_set;
        @(posedge clk) disable iff (!nrst)
        (gsm == `CCG_GSM_FALL && !gate_now && st.gate_d) |=> capture_disable_flag;
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("fall did not set");

    property p_dis_block;
        @(posedge clk) disable iff (!nrst)
        (gsm != `CCG_GSM_LEVEL && st.dis) |=> !capture_event;
    endproperty
    a_dis_block: assert property (p_dis_block) else $error("capture while disabled");

    property p_pin_release;
        @(posedge clk) disable iff (!nrst)
        !st.ctrl[`CCG_BIT_PIN_STEER] |=> !compare_output_pin_oe;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin not released");

    property p_oe_hold;
        @(posedge clk) disable iff (!nrst)
        (st.ctrl[`CCG_BIT_OE_SYNC] && !tb_reset && !tb_rollover) |=> $stable(st.oe_applied);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("early enable update");

    property p_aux_off;
        @(posedge clk) disable iff (!nrst)
        (auxsel == `CCG_AUX_OFF) |=> !aux_out;
    endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux active when off");

    property p_src_sel;
        @(posedge clk) disable iff (!nrst)
        (gsm == `CCG_GSM_LEVEL && gate_now && pins_s[srcsel] && !st.src_d) |=> capture_event;
    endproperty
    a_src_sel: assert property (p_src_sel) else $error("selected source missed");
endmodule
`default_nettype wire

// ===== bench/ccg_src_model.sv
// far-side model of the capture sources and the gating pin
`timescale 1ns/1ps
`default_nettype none
module ccg_src_model (
    input  wire logic       clk,
    output var  logic [7:0] capture_sources,
    output var  logic       gate_in
);
    initial
    begin
        capture_sources = 8'h00;
        gate_in         = 1'b0;
    end
    // one source high for four cycles, then a quiet gap
    task automatic pulse(input int i);
        @(posedge clk);
        capture_sources[i] <= 1'b1;
        repeat (4) @(posedge clk);
        capture_sources[i] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // gating level change, then settle past the synchroniser
    task automatic gate(input logic v);
        @(posedge clk);
        gate_in <= v;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== bench/test_capture_compare_gating_control.sv
// self-checking bench for the capture/compare gating control slice
`timescale 1ns/1ps
`default_nettype none
`include "ccg_params.svh"
module test_capture_compare_gating_control;
    logic        clk, nrst, read, write, waitrequest, tb_rollover, tb_reset;
    logic        mode_signal, compare_event, timer_mode, compare_wave, out_enable_req;
    logic        gate_in, capture_event, aux_out, capture_disable_flag, irq, pin, pin_oe;
    logic [3:0]  address;
    logic [31:0] writedata, readdata;
    logic [7:0]  capture_sources;
    int          error_cnt, checks, cap_n, aux_n, cyc, n;
    ccg_src_model ccg_src_model_i (.clk(clk), .capture_sources(capture_sources),
        .gate_in(gate_in));
    ccg_top ccg_top_i (.clk(clk), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .capture_sources(capture_sources), .gate_in(gate_in),
        .tb_rollover(tb_rollover), .tb_reset(tb_reset), .mode_signal(mode_signal),
        .compare_event(compare_event), .timer_mode(timer_mode),
        .compare_wave(compare_wave), .out_enable_req(out_enable_req),
        .compare_output_pin(pin), .compare_output_pin_oe(pin_oe),
        .capture_event(capture_event), .aux_out(aux_out),
        .capture_disable_flag(capture_disable_flag), .irq(irq));
    // ==========================================
    // clock, watchers and timeout
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (capture_event === 1'b1) cap_n++;
        if (aux_out === 1'b1) aux_n++;
        if (cyc > 20000)
        begin
            error_cnt++;
            close_out();
        end
    end
    // ==========================================
    // compare, verdict and avalon tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bus(input logic rw, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        address   <= a;
        writedata <= d;
        write     <= ~rw;
        read      <= rw;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        read  <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b1, a, 32'h0);
        chk("readdata", readdata, e);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
        repeat (2) @(posedge clk);
    endtask
    task automatic ev();
        @(posedge clk) tb_rollover <= 1'b1;
        @(posedge clk) tb_rollover <= 1'b0;
        mode_signal <= 1'b1;
        @(posedge clk) mode_signal <= 1'b0;
        compare_event <= 1'b1;
        @(posedge clk) compare_event <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic cap(input int i, input int j, input int e);
        n = cap_n;
        ccg_src_model_i.pulse(i);
        ccg_src_model_i.pulse(j);
        chk("captures", 32'(cap_n - n), 32'(e));
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        {nrst, read, write, tb_rollover, tb_reset, mode_signal, compare_event} = '0;
        {timer_mode, address, writedata} = '0;
        compare_wave   = 1'b1;
        out_enable_req = 1'b1;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(`CCG_ADDR_CTRL, 32'h0);
        wr(`CCG_ADDR_CTRL, 32'hffff_ffff);
        rd(`CCG_ADDR_CTRL, 32'h81df);
        rd(4'h2, 32'h0);
        wr(`CCG_ADDR_CTRL, 32'h0100);
        chk("pin_oe", 32'(pin_oe), 32'h1);
        chk("pin", 32'(pin), 32'h1);
        compare_wave <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pin", 32'(pin), 32'h0);
        compare_wave <= 1'b1;
        wr(`CCG_ADDR_CTRL, 32'h8100);
        out_enable_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk("pin_oe", 32'(pin_oe), 32'h1);
        ev();
        chk("pin_oe", 32'(pin_oe), 32'h0);
        out_enable_req <= 1'b1;
        @(posedge clk) tb_reset <= 1'b1;
        @(posedge clk) tb_reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pin_oe", 32'(pin_oe), 32'h1);
        wr(`CCG_ADDR_CTRL, 32'h0);
        chk("pin_oe", 32'(pin_oe), 32'h0);
        chk("pin", 32'(pin), 32'h0);
        ccg_src_model_i.gate(1'b1);
        for (int i = 0; i < 8; i++)
        begin
            wr(`CCG_ADDR_CTRL, 32'(i));
            cap(i, (i + 1) % 8, 1);
        end
        wr(`CCG_ADDR_CTRL, 32'h0);
        ccg_src_model_i.gate(1'b0);
        cap(0, 0, 0);
        wr(`CCG_ADDR_CTRL, 32'h0080);
        ccg_src_model_i.gate(1'b1);
        ccg_src_model_i.gate(1'b0);
        chk("disable", 32'(capture_disable_flag), 32'h1);
        cap(0, 0, 0);
        wr(`CCG_ADDR_CTRL, 32'h0040);
        ccg_src_model_i.gate(1'b1);
        chk("disable", 32'(capture_disable_flag), 32'h0);
        cap(0, 1, 1);
        wr(`CCG_ADDR_CTRL, 32'h00c0);
        cap(0, 0, 0);
        for (int m = 0; m < 5; m++)
        begin
            timer_mode <= (m == 4);
            wr(`CCG_ADDR_CTRL, 32'(((m == 4) ? 3 : m) << 3));
            n = aux_n;
            ev();
            chk("aux", 32'(aux_n - n), (m == 0 || m == 4) ? 32'h0 : 32'h1);
        end
        rd(`CCG_ADDR_STATUS, 32'h7);
        wr(`CCG_ADDR_STATUS, 32'h7);
        rd(`CCG_ADDR_STATUS, 32'h0);
        wr(`CCG_ADDR_MASK, 32'h1);
        rd(`CCG_ADDR_MASK, 32'h1);
        wr(`CCG_ADDR_CTRL, 32'h0);
        cap(0, 1, 1);
        chk("irq", 32'(irq), 32'h1);
        rd(`CCG_ADDR_STATUS, 32'h1);
        wr(`CCG_ADDR_MASK, 32'h0);
        chk("irq", 32'(irq), 32'h0);
        wr(`CCG_ADDR_MASK, 32'h1);
        wr(`CCG_ADDR_STATUS, 32'h1);
        chk("irq", 32'(irq), 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
